// *** rtl/ehc_map.vh ***
// Register map, field positions and timing counts for the check-unit host controller
`ifndef EHC_MAP_VH
`define EHC_MAP_VH

// -------------------------------------------------
// Register offsets (byte addresses, 8-bit address)
// -------------------------------------------------
`define EHC_REG_CTRL 8'h00
`define EHC_REG_WDATA 8'h04
`define EHC_REG_RDATA 8'h08
`define EHC_REG_STATUS 8'h0c
`define EHC_REG_SYND 8'h10
`define EHC_REG_CLEAR 8'h14

// -------------------------------------------------
// Field positions
// -------------------------------------------------
`define EHC_CTRL_WRITE 0
`define EHC_CTRL_READ 1
`define EHC_CTRL_ADDR_LO 4
`define EHC_CTRL_ADDR_HI 7
`define EHC_ST_BUSY 0
`define EHC_ST_CLEAN 1
`define EHC_ST_FIXED 2
`define EHC_ST_UNCORR 3
`define EHC_ST_SFLAG 4
`define EHC_ST_MFLAG 5
`define EHC_ST_CBONLY 6
`define EHC_CLEAR_UNCORR 0

// -------------------------------------------------
// Sizes and reset values
// -------------------------------------------------
`define EHC_DW 32
`define EHC_CW 7
`define EHC_AW 4
`define EHC_DEPTH 16
`define EHC_SYND_RESET 7'h7f

// -------------------------------------------------
// Timing
// -------------------------------------------------
`define EHC_CLK_MHZ 25
`define EHC_SETTLE_NS 40
`define EHC_SETTLE_CYC (((`EHC_SETTLE_NS * `EHC_CLK_MHZ) + 999) / 1000)

`endif

// *** rtl/ehc_mem.v ***
// Word store holding data and check bits side by side
`include "ehc_map.vh"

module ehc_mem (
   // Clock
   input wire core_clk,
   // Write side
   input wire wr_en,
   input wire [`EHC_AW-1:0] wr_addr,
   input wire [`EHC_DW+`EHC_CW-1:0] wr_word,
   // Read side
   input wire [`EHC_AW-1:0] rd_addr,
   output reg [`EHC_DW+`EHC_CW-1:0] rd_word
);

   reg [`EHC_DW+`EHC_CW-1:0] store [0:`EHC_DEPTH-1];

   // -------------------------------------------------
   // Synchronous write, registered read
   // -------------------------------------------------
   always @(posedge core_clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_word;
      end
      rd_word <= store[rd_addr];
   end

endmodule

// *** rtl/ehc_ctrl.v ***
// Host controller that drives the 32-bit check and correct unit through its pins
// Functional notes
// - Host stores the seven check bits with the data word for later reads.
// - Three or more bad bits give an unreliable classification.
// - Host uses read data directly only when both flags are high.
// - Single flag low, multiple high: host runs the correction sequence first.
// - Both flags low: host marks word uncorrectable and raises an interrupt.
`include "ehc_map.vh"

module ehc_ctrl (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Software port
   input wire [7:0] sw_addr,
   input wire [31:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   output reg [31:0] sw_rdata,
   // Uncorrectable word indication
   output reg uncorr_irq,
   // Unit controls
   output reg mode_select_high,
   output reg mode_select_low,
   output reg output_latch_enable_n,
   output reg data_out_enable_n,
   output reg check_out_enable_n,
   // Unit flags
   input wire single_fault_flag_n,
   input wire multi_fault_flag_n,
   // Data bus pin
   input wire [`EHC_DW-1:0] data_bus_in,
   output reg [`EHC_DW-1:0] data_bus_out,
   output reg data_bus_oe,
   // Check bus pin
   input wire [`EHC_CW-1:0] check_bus_in,
   output reg [`EHC_CW-1:0] check_bus_out,
   output reg check_bus_oe
);

   // -------------------------------------------------
   // States and constants
   // -------------------------------------------------
   localparam [3:0] S_IDLE = 4'h0;
   localparam [3:0] S_WR_DRIVE = 4'h1;
   localparam [3:0] S_WR_WAIT = 4'h2;
   localparam [3:0] S_WR_STORE = 4'h3;
   localparam [3:0] S_RD_FETCH = 4'h4;
   localparam [3:0] S_RD_DRIVE = 4'h5;
   localparam [3:0] S_RD_WAIT = 4'h6;
   localparam [3:0] S_RD_FLAG = 4'h7;
   localparam [3:0] S_CO_LATCH = 4'h8;
   localparam [3:0] S_CO_TURN = 4'h9;
   localparam [3:0] S_CO_WAIT = 4'ha;
   localparam [3:0] S_CO_TAKE = 4'hb;
   localparam [3:0] S_DONE = 4'hc;
   localparam integer SETTLE = `EHC_SETTLE_CYC;

   reg [3:0] state;
   reg [3:0] cnt;
   reg [`EHC_AW-1:0] addr;
   reg [`EHC_DW-1:0] wdata;
   reg [`EHC_DW-1:0] rdata;
   reg [`EHC_CW-1:0] synd;
   reg [`EHC_DW-1:0] mem_data;
   reg st_clean;
   reg st_fixed;
   reg st_cbonly;
   reg st_sflag;
   reg st_mflag;
   reg mem_wr;
   wire [`EHC_DW+`EHC_CW-1:0] mem_word;
   wire busy;
   wire clr_uncorr;
   reg set_uncorr;

   // Wait counter reached the settle time
   function settled;
      input [3:0] c;
      begin
         settled = ({28'h000_0000, c} + 32'h0000_0001 >= SETTLE);
      end
   endfunction

   assign busy = (state != S_IDLE);
   assign clr_uncorr = sw_wr && (sw_addr == `EHC_REG_CLEAR) && sw_wdata[`EHC_CLEAR_UNCORR];

   // -------------------------------------------------
   // Word store
   // -------------------------------------------------
   ehc_mem u_mem (
      .core_clk(core_clk),
      .wr_en(mem_wr),
      .wr_addr(addr),
      .wr_word({check_bus_in, wdata}),
      .rd_addr(addr),
      .rd_word(mem_word)
   );

   // -------------------------------------------------
   // Sequencer
   // -------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         state <= S_IDLE;
         cnt <= 4'h0;
         addr <= {`EHC_AW{1'b0}};
         wdata <= {`EHC_DW{1'b0}};
         rdata <= {`EHC_DW{1'b0}};
         synd <= `EHC_SYND_RESET;
         mem_data <= {`EHC_DW{1'b0}};
         st_clean <= 1'b0;
         st_fixed <= 1'b0;
         st_cbonly <= 1'b0;
         st_sflag <= 1'b1;
         st_mflag <= 1'b1;
         mem_wr <= 1'b0;
         set_uncorr <= 1'b0;
         mode_select_high <= 1'b1;
         mode_select_low <= 1'b0;
         output_latch_enable_n <= 1'b0;
         data_out_enable_n <= 1'b1;
         check_out_enable_n <= 1'b1;
         data_bus_out <= {`EHC_DW{1'b0}};
         data_bus_oe <= 1'b0;
         check_bus_out <= {`EHC_CW{1'b0}};
         check_bus_oe <= 1'b0;
      end else begin
         mem_wr <= 1'b0;
         set_uncorr <= 1'b0;
         case (state)
            S_IDLE: begin
               if (sw_wr && sw_addr == `EHC_REG_WDATA) begin
                  wdata <= sw_wdata;
               end
               if (sw_wr && sw_addr == `EHC_REG_CTRL) begin
                  addr <= sw_wdata[`EHC_CTRL_ADDR_HI:`EHC_CTRL_ADDR_LO];
                  if (sw_wdata[`EHC_CTRL_WRITE]) begin
                     state <= S_WR_DRIVE;
                  end else if (sw_wdata[`EHC_CTRL_READ]) begin
                     state <= S_RD_FETCH;
                  end
               end
            end
            S_WR_DRIVE: begin
               // Write mode: unit takes data, drives check bits
               mode_select_high <= 1'b0;
               mode_select_low <= 1'b0;
               check_out_enable_n <= 1'b0;
               data_bus_out <= wdata;
               data_bus_oe <= 1'b1;
               cnt <= 4'h0;
               state <= S_WR_WAIT;
            end
            S_WR_WAIT: begin
               cnt <= cnt + 4'h1;
               if (settled(cnt)) begin
                  mem_wr <= 1'b1;
                  state <= S_WR_STORE;
               end
            end
            S_WR_STORE: begin
               check_out_enable_n <= 1'b1;
               data_bus_oe <= 1'b0;
               mode_select_high <= 1'b1;
               state <= S_IDLE;
            end
            S_RD_FETCH: begin
               state <= S_RD_DRIVE;
            end
            S_RD_DRIVE: begin
               // Read and flag: both buses are unit inputs
               mode_select_high <= 1'b1;
               mode_select_low <= 1'b0;
               output_latch_enable_n <= 1'b0;
               data_bus_out <= mem_word[`EHC_DW-1:0];
               check_bus_out <= mem_word[`EHC_DW+`EHC_CW-1:`EHC_DW];
               mem_data <= mem_word[`EHC_DW-1:0];
               data_bus_oe <= 1'b1;
               check_bus_oe <= 1'b1;
               cnt <= 4'h0;
               state <= S_RD_WAIT;
            end
            S_RD_WAIT: begin
               cnt <= cnt + 4'h1;
               if (settled(cnt)) begin
                  state <= S_RD_FLAG;
               end
            end
            S_RD_FLAG: begin
               st_sflag <= single_fault_flag_n;
               st_mflag <= multi_fault_flag_n;
               st_clean <= 1'b0;
               st_fixed <= 1'b0;
               st_cbonly <= 1'b0;
               synd <= `EHC_SYND_RESET;
               if (single_fault_flag_n && multi_fault_flag_n) begin
                  rdata <= mem_data;
                  st_clean <= 1'b1;
                  state <= S_DONE;
               end else if (multi_fault_flag_n) begin
                  state <= S_CO_LATCH;
               end else begin
                  set_uncorr <= 1'b1;
                  state <= S_DONE;
               end
            end
            S_CO_LATCH: begin
               // Latch the read word inside the unit
               mode_select_low <= 1'b1;
               output_latch_enable_n <= 1'b0;
               state <= S_CO_TURN;
            end
            S_CO_TURN: begin
               data_bus_oe <= 1'b0;
               check_bus_oe <= 1'b0;
               state <= S_CO_WAIT;
               cnt <= 4'h0;
            end
            S_CO_WAIT: begin
               data_out_enable_n <= 1'b0;
               check_out_enable_n <= 1'b0;
               cnt <= cnt + 4'h1;
               if (settled(cnt)) begin
                  state <= S_CO_TAKE;
               end
            end
            S_CO_TAKE: begin
               rdata <= data_bus_in;
               synd <= check_bus_in;
               st_fixed <= 1'b1;
               st_cbonly <= (data_bus_in == mem_data);
               data_out_enable_n <= 1'b1;
               check_out_enable_n <= 1'b1;
               state <= S_DONE;
            end
            S_DONE: begin
               data_bus_oe <= 1'b0;
               check_bus_oe <= 1'b0;
               mode_select_high <= 1'b1;
               mode_select_low <= 1'b0;
               state <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------
   // Uncorrectable indication, set wins over clear
   // -------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         uncorr_irq <= 1'b0;
      end else if (set_uncorr) begin
         uncorr_irq <= 1'b1;
      end else if (clr_uncorr) begin
         uncorr_irq <= 1'b0;
      end
   end

   // -------------------------------------------------
   // Register read port
   // -------------------------------------------------
   always @(posedge core_clk) begin
      if (srst) begin
         sw_rdata <= 32'h0000_0000;
      end else if (sw_rd) begin
         case (sw_addr)
            `EHC_REG_CTRL: sw_rdata <= {24'h00_0000, addr, 4'h0};
            `EHC_REG_WDATA: sw_rdata <= wdata;
            `EHC_REG_RDATA: sw_rdata <= rdata;
            `EHC_REG_STATUS: sw_rdata <= {25'h000_0000, st_cbonly, st_mflag, st_sflag, uncorr_irq,
                                          st_fixed, st_clean, busy};
            `EHC_REG_SYND: sw_rdata <= {25'h000_0000, synd};
            default: sw_rdata <= 32'h0000_0000;
         endcase
      end else begin
         sw_rdata <= 32'h0000_0000;
      end
   end

endmodule

// *** test/ehc_ctrl_chk.sv ***
// Assertion checker on the host controller ports
module ehc_ctrl_chk (
   // Clock and reset
   input wire core_clk,
   input wire srst,
   // Software port
   input wire [7:0] sw_addr,
   input wire [31:0] sw_wdata,
   input wire sw_wr,
   input wire sw_rd,
   input wire [31:0] sw_rdata,
   input wire uncorr_irq,
   // Unit pins
   input wire mode_select_high,
   input wire mode_select_low,
   input wire output_latch_enable_n,
   input wire data_out_enable_n,
   input wire check_out_enable_n,
   input wire single_fault_flag_n,
   input wire multi_fault_flag_n,
   input wire data_bus_oe,
   input wire check_bus_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (srst);
   wire wmode = !mode_select_high && !mode_select_low;
   wire both = mode_select_high && mode_select_low;
   wire dbl = !single_fault_flag_n && !multi_fault_flag_n;
   wire sngl = !single_fault_flag_n && multi_fault_flag_n;
   wire clr = sw_wr && sw_addr == 8'h14 && sw_wdata[0];
   data_drive_a: assert property (!data_out_enable_n |-> both && !data_bus_oe)
      else $error("data bus driven wrongly");
   check_drive_a: assert property (!check_out_enable_n |-> (wmode || both) && !check_bus_oe)
      else $error("check bus driven wrongly");
   write_mode_a: assert property (wmode |-> data_bus_oe && !check_out_enable_n && data_out_enable_n)
      else $error("write mode pins wrong");
   read_flag_a: assert property (mode_select_high && !mode_select_low |-> data_out_enable_n && check_out_enable_n)
      else $error("read mode enables wrong");
   latch_entry_a: assert property ($rose(both) |-> data_bus_oe && !output_latch_enable_n ##1 !data_bus_oe)
      else $error("latch entry wrong");
   fix_cause_a: assert property ($rose(both) |-> $past(sngl))
      else $error("correction without single fault");
   irq_cause_a: assert property ($rose(uncorr_irq) |-> $past(dbl) || $past(dbl, 2) || $past(dbl, 3))
      else $error("irq without double fault");
   irq_clear_a: assert property ($fell(uncorr_irq) |-> $past(clr))
      else $error("irq dropped without clear");
   irq_sticky_a: assert property (uncorr_irq && !clr |=> uncorr_irq)
      else $error("irq not sticky");
   rdata_idle_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
      else $error("read data outside slot");
endmodule
bind ehc_ctrl ehc_ctrl_chk u_ehc_ctrl_chk (
   .core_clk(core_clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
   .sw_rd(sw_rd), .sw_rdata(sw_rdata), .uncorr_irq(uncorr_irq), .mode_select_high(mode_select_high),
   .mode_select_low(mode_select_low), .output_latch_enable_n(output_latch_enable_n),
   .data_out_enable_n(data_out_enable_n), .check_out_enable_n(check_out_enable_n),
   .single_fault_flag_n(single_fault_flag_n), .multi_fault_flag_n(multi_fault_flag_n),
   .data_bus_oe(data_bus_oe), .check_bus_oe(check_bus_oe)
);

// *** test/ehc_unit.sv ***
// Behavioural model of the check and correct unit
module ehc_unit #(
   parameter logic [6:0] INV = 7'h03
) (
   // Controls and injected memory faults
   input wire logic mode_select_high,
   input wire logic mode_select_low,
   input wire logic output_latch_enable_n,
   input wire logic data_out_enable_n,
   input wire logic check_out_enable_n,
   input wire logic [38:0] flip,
   // Host side of the buses
   input wire logic [31:0] hd,
   input wire logic hd_oe,
   input wire logic [6:0] hc,
   input wire logic hc_oe,
   // Flags and bus levels
   output logic single_fault_flag_n,
   output logic multi_fault_flag_n,
   output logic [31:0] data_bus,
   output logic [6:0] check_bus
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [255:0] COLS = 256'h763e1f4f6773797c_70683864544c1c52_322a1a460e614929_1925150d43231307;
   logic [38:0] held;
   logic [31:0] fix;
   logic [6:0] s;
   logic hit;
   wire wmode = !mode_select_high && !mode_select_low;
   wire both = mode_select_high && mode_select_low;
   function automatic logic [6:0] gen(input logic [31:0] d);
      gen = INV;
      for (int j = 0; j < 32; j++) begin
         if (d[j]) begin
            gen ^= COLS[j*8+:7];
         end
      end
   endfunction
   always_latch begin
      if (!(both && !output_latch_enable_n)) begin
         held = {hc, hd};
      end
   end
   always_comb begin
      s = gen(held[31:0]) ^ held[38:32];
      fix = held[31:0];
      hit = $countones(s) == 1;
      for (int j = 0; j < 32; j++) begin
         if (s == COLS[j*8+:7]) begin
            fix[j] = !fix[j];
            hit = 1'b1;
         end
      end
   end
   // Faults enter the stored word: check from the intended data, then flipped
   wire logic [6:0] wcb = gen(hd ^ flip[31:0]) ^ flip[38:32];
   assign single_fault_flag_n = wmode || s == 7'h0;
   assign multi_fault_flag_n = wmode || s == 7'h0 || hit;
   assign data_bus = hd_oe ? hd : (both && !data_out_enable_n) ? fix : ~hd;
   assign check_bus = hc_oe ? hc : check_out_enable_n ? ~hc : wmode ? wcb : both ? ~s : ~hc;
endmodule

// *** test/tb_ehc_ctrl.sv ***
// Testbench for the check-unit host controller
module tb_ehc_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, srst = 1, sw_wr = 0, sw_rd = 0;
   logic [7:0] sw_addr = 0;
   logic [31:0] sw_wdata = 0, sw_rdata, dbi, dbo, d;
   logic [38:0] flip = 0;
   logic [6:0] cbi, cbo;
   logic irq, msh, msl, len, doe, coe, sf, mf, dboe, cboe;
   int fail_count = 0, compares = 0;
   always #20 core_clk = ~core_clk;
   ehc_ctrl u_ehc_ctrl (.core_clk(core_clk), .srst(srst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .uncorr_irq(irq), .mode_select_high(msh),
      .mode_select_low(msl), .output_latch_enable_n(len), .data_out_enable_n(doe), .check_out_enable_n(coe),
      .single_fault_flag_n(sf), .multi_fault_flag_n(mf), .data_bus_in(dbi), .data_bus_out(dbo),
      .data_bus_oe(dboe), .check_bus_in(cbi), .check_bus_out(cbo), .check_bus_oe(cboe));
   ehc_unit u_ehc_unit (.mode_select_high(msh), .mode_select_low(msl), .output_latch_enable_n(len),
      .data_out_enable_n(doe), .check_out_enable_n(coe), .flip(flip), .hd(dbo), .hd_oe(dboe), .hc(cbo),
      .hc_oe(cboe), .single_fault_flag_n(sf), .multi_fault_flag_n(mf), .data_bus(dbi), .check_bus(cbi));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      sw_addr <= a;
      sw_wdata <= v;
      sw_wr <= 1;
      @(posedge core_clk);
      sw_wr <= 0;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      sw_addr <= a;
      sw_rd <= 1;
      @(posedge core_clk);
      sw_rd <= 0;
      @(negedge core_clk);
      v = sw_rdata;
      @(posedge core_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask
   task automatic poll();
      d = 32'h1;
      for (int i = 0; i < 40 && d[0] !== 1'b0; i++) begin
         rd(8'h0c, d);
      end
      chk({31'h0, d[0]}, 32'h0);
   endtask
   task automatic op(input logic [31:0] c);
      wr(8'h00, c);
      poll();
   endtask
   task automatic end_sim();
      if (fail_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ----
   // Test sequence
   // ----
   initial begin
      repeat (8) @(posedge core_clk);
      srst <= 0;
      @(posedge core_clk);
      rc(8'h10, 32'h7f);
      rc(8'h18, 32'h0);
      wr(8'h04, 32'hc0ffee11);
      op(32'h31);
      wr(8'h04, 32'h0);
      op(32'h51);
      op(32'h32);
      rc(8'h0c, 32'h32);
      rc(8'h08, 32'hc0ffee11);
      for (int j = 0; j < 32; j += 13) begin
         flip = 39'h1 << j;
         wr(8'h04, 32'hc0ffee11 ^ flip[31:0]);
         op(32'h31);
         op(32'h32);
         rc(8'h0c, 32'h24);
         rc(8'h08, 32'hc0ffee11);
         rd(8'h10, d);
         chk({31'h0, $countones(~d[6:0]) inside {3, 5}}, 32'h1);
      end
      wr(8'h04, 32'hc0ffee11);
      for (int k = 0; k < 7; k++) begin
         flip = 39'h1 << (32 + k);
         op(32'h31);
         op(32'h32);
         rc(8'h0c, 32'h64);
         rc(8'h08, 32'hc0ffee11);
         rc(8'h10, {25'h0, ~(7'h1 << k)});
      end
      for (int m = 0; m < 3; m++) begin
         flip = m == 0 ? 39'h5 : m == 1 ? 39'h1_00000001 : 39'h3_00000000;
         wr(8'h04, 32'hc0ffee11 ^ flip[31:0]);
         op(32'h31);
         op(32'h32);
         rc(8'h0c, 32'h08);
         rc(8'h08, 32'hc0ffee11);
         chk({31'h0, irq}, 32'h1);
         wr(8'h14, 32'h1);
         chk({31'h0, irq}, 32'h0);
      end
      flip = 39'h3_00000000;
      wr(8'h04, 32'h0);
      op(32'h51);
      op(32'h52);
      rc(8'h0c, 32'h08);
      wr(8'h14, 32'h1);
      flip = 39'h7c_00000000;
      wr(8'h04, 32'hffffffff);
      op(32'h71);
      op(32'h72);
      rd(8'h0c, d);
      chk({31'h0, d[1]}, 32'h0);
      flip = 0;
      wr(8'h00, 32'h71);
      wr(8'h04, 32'h12345678);
      poll();
      rc(8'h04, 32'hffffffff);
      op(32'h72);
      rc(8'h08, 32'hffffffff);
      rc(8'h00, 32'h70);
      end_sim();
   end
   initial begin
      #200us;
      fail_count++;
      end_sim();
   end
endmodule
